// *** shared/mds_defs.svh ***
// Constants of the motor driver setup port: field positions, reset values
// and timing counts.
// Assumes a 10 MHz system clock.
`ifndef MDS_DEFS_SVH
`define MDS_DEFS_SVH

`define MDS_WORD_W 16
`define MDS_CFG_RESET 16'h0000
`define MDS_MS_LSB 0
`define MDS_MS_MSB 2
`define MDS_BLK_AB_LSB 3
`define MDS_BLK_AB_MSB 4
`define MDS_BLK_CD_LSB 5
`define MDS_BLK_CD_MSB 6
`define MDS_GAIN_AB_BIT 10
`define MDS_GAIN_CD_BIT 11
`define MDS_OSC_LSB 14
`define MDS_OSC_MSB 15
`define MDS_CLK_PERIOD_NS 100
// Blanking times in nanoseconds.
`define MDS_BLANK_0_NS 6250
`define MDS_BLANK_1_NS 7500
`define MDS_BLANK_2_NS 3750
`define MDS_BLANK_3_NS 5000
// Every blanking time rounds down to whole cycles.
`define MDS_BLANK_CYC(ns) ((ns) / `MDS_CLK_PERIOD_NS)
// Chopping oscillator half periods in nanoseconds, rounded to whole ns.
`define MDS_OSC_0_NS 1250
`define MDS_OSC_1_NS 2500
`define MDS_OSC_2_NS 943
`define MDS_OSC_3_NS 625
// Shortest wait before the latch may rise after sleep ends.
`define MDS_WAKE_US 50
`define MDS_WAKE_CYC ((`MDS_WAKE_US * 1000 + `MDS_CLK_PERIOD_NS - 1) / `MDS_CLK_PERIOD_NS)

`endif

// *** shared/mds_pkg.sv ***
// Types of the motor driver setup port.
// Assumes nothing beyond a SystemVerilog tool.
package mds_pkg;
    typedef enum logic [2:0] {
        MDS_MS_TWO_STEP = 3'h0,
        MDS_MS_STEP_LDC = 3'h1,
        MDS_MS_STEP_2SDC = 3'h2,
        MDS_MS_LDC_2SDC = 3'h3,
        MDS_MS_TWO_LDC = 3'h4,
        MDS_MS_FOUR_SDC = 3'h5,
        MDS_MS_LARGE_STEP = 3'h6,
        MDS_MS_ULTRA_DC = 3'h7
    } mds_motor_sel_t;

    typedef enum logic [1:0] {
        MDS_CH_RUN = 2'b00,
        MDS_CH_OFF = 2'b01,
        MDS_CH_BLANK = 2'b11
    } mds_chop_state_t;
endpackage : mds_pkg

// *** logic/mds_chopper.sv ***
// One bridge current chopper: switches the bridge off for a fixed time
// when its sense comparator trips, then blanks the comparator.
// Assumes the trip input is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "mds_defs.svh"

module mds_chopper
    import mds_pkg::*;
#(
    parameter int CNT_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic trip,
    input wire logic [CNT_W-1:0] off_cycles,
    input wire logic [CNT_W-1:0] blank_cycles,
    output logic drive
);
    mds_chop_state_t state;
    logic [CNT_W-1:0] count;

    // --------------------------------------------------------------
    // Chopping sequence
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= MDS_CH_RUN;
            count <= '0;
        end else if (!run) begin
            state <= MDS_CH_RUN;
            count <= '0;
        end else begin
            case (state)
                MDS_CH_RUN: begin
                    if (trip) begin
                        state <= MDS_CH_OFF;
                        count <= off_cycles;
                    end
                end
                MDS_CH_OFF: begin
                    if (count <= 1) begin
                        state <= MDS_CH_BLANK;
                        count <= blank_cycles;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                MDS_CH_BLANK: begin
                    if (count <= 1) begin
                        state <= MDS_CH_RUN;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                default: begin
                    state <= MDS_CH_RUN;
                end
            endcase
        end
    end

    assign drive = run && (state != MDS_CH_OFF);
endmodule : mds_chopper
`default_nettype wire

// *** logic/mds_setup_port.sv ***
// Setup port and bridge front end of a four bridge motor driver.
// Assumes serial_clock_ab is a link clock from the controller that may
// stop outside messages; all other pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "mds_defs.svh"

module mds_setup_port
    import mds_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_clock_ab,
    input wire logic device_reset_in,
    input wire logic low_power_select_n,
    input wire logic latch_a,
    input wire logic serial_in_ab,
    input wire logic pin_b_enable,
    input wire logic pin_b_phase,
    input wire logic pin_c_enable,
    input wire logic pin_c_phase,
    input wire logic pin_d_enable,
    input wire logic pin_d_phase,
    input wire logic [3:0] sense_over_ref,
    output logic [15:0] motor_config_word,
    output logic [15:0] extended_word,
    output logic config_update,
    output logic bridges_active,
    output logic [3:0] bridge_drive,
    output logic [3:0] bridge_phase,
    output logic [2:0] motor_select,
    output logic [1:0] chop_osc_freq_sel,
    output logic sense_gain_pair1,
    output logic sense_gain_pair2,
    output logic [1:0] blank_time_pair1,
    output logic [1:0] blank_time_pair2,
    output logic chop_osc,
    output logic wake_ready
);
    localparam int WAKE_CYC = `MDS_WAKE_CYC;

    // --------------------------------------------------------------
    // Pin synchronisers, three stages each
    // --------------------------------------------------------------
    localparam int NS = 12;
    logic [NS-1:0] pins;
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic [NS-1:0] pin_q;

    assign pins = {sense_over_ref, pin_d_phase, pin_d_enable, pin_c_phase,
                   pin_c_enable, pin_b_phase, pin_b_enable,
                   serial_in_ab, latch_a};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= pins;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change is accepted once the second and third stages agree.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_q <= '0;
        end else begin
            for (int i = 0; i < NS; i++) begin
                if (s2[i] == s3[i]) begin
                    pin_q[i] <= s3[i];
                end
            end
        end
    end

    // Reset input and sleep pin have their own chains, reset low at rst.
    logic rin1, rin2, rin3, rin_q;
    logic slp1, slp2, slp3, slp_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rin1 <= 1'b0;
            rin2 <= 1'b0;
            rin3 <= 1'b0;
            rin_q <= 1'b0;
            slp1 <= 1'b0;
            slp2 <= 1'b0;
            slp3 <= 1'b0;
            slp_q <= 1'b0;
        end else begin
            rin1 <= device_reset_in;
            rin2 <= rin1;
            rin3 <= rin2;
            slp1 <= low_power_select_n;
            slp2 <= slp1;
            slp3 <= slp2;
            if (rin2 == rin3) begin
                rin_q <= rin3;
            end
            if (slp2 == slp3) begin
                slp_q <= slp3;
            end
        end
    end

    logic latch_q;
    logic data_q;
    logic latch_d;
    logic slp_d;

    assign latch_q = pin_q[0];
    assign data_q = pin_q[1];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_d <= 1'b0;
            slp_d <= 1'b0;
        end else begin
            latch_d <= latch_q;
            slp_d <= slp_q;
        end
    end

    // --------------------------------------------------------------
    // Link domain shift register
    // --------------------------------------------------------------
    // Only the first serial port feeds this register.
    logic [15:0] shift_word;

    always_ff @(negedge serial_clock_ab or posedge rst) begin
        if (rst) begin
            shift_word <= '0;
        end else begin
            shift_word <= {shift_word[14:0], serial_in_ab};
        end
    end

    // The word is stable while the latch is high, since the controller
    // stops the serial clock before raising it. The latch edge is seen
    // here four cycles late, after the last falling clock edge.
    logic [15:0] word_x1;
    logic [15:0] word_x2;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            word_x1 <= '0;
            word_x2 <= '0;
        end else begin
            word_x1 <= shift_word;
            word_x2 <= word_x1;
        end
    end

    // --------------------------------------------------------------
    // Mode control
    // --------------------------------------------------------------
    logic setup_mode;
    logic latch_rise;
    logic wake_rise;

    assign setup_mode = rin_q && !slp_q;
    assign latch_rise = latch_q && !latch_d;
    assign wake_rise = slp_q && !slp_d;

    // Latch still acts at the instant sleep ends, so a simultaneous
    // rise stores whatever was shifted.
    logic latch_ok;
    assign latch_ok = rin_q && latch_rise && (!slp_q || wake_rise);

    // --------------------------------------------------------------
    // Configuration and extended registers
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            motor_config_word <= `MDS_CFG_RESET;
            extended_word <= `MDS_CFG_RESET;
            config_update <= 1'b0;
        end else begin
            config_update <= 1'b0;
            if (!rin_q) begin
                motor_config_word <= `MDS_CFG_RESET;
                extended_word <= `MDS_CFG_RESET;
            end else if (latch_ok) begin
                if (!data_q) begin
                    motor_config_word <= word_x2;
                    config_update <= 1'b1;
                end else begin
                    extended_word <= word_x2;
                end
            end else if (setup_mode && slp_d) begin
                motor_config_word <= `MDS_CFG_RESET;
                extended_word <= `MDS_CFG_RESET;
            end
        end
    end

    // --------------------------------------------------------------
    // Field decode
    // --------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            motor_select <= '0;
            chop_osc_freq_sel <= '0;
            sense_gain_pair1 <= 1'b0;
            sense_gain_pair2 <= 1'b0;
            blank_time_pair1 <= '0;
            blank_time_pair2 <= '0;
        end else begin
            motor_select <=
                motor_config_word[`MDS_MS_MSB:`MDS_MS_LSB];
            chop_osc_freq_sel <=
                motor_config_word[`MDS_OSC_MSB:`MDS_OSC_LSB];
            sense_gain_pair1 <= motor_config_word[`MDS_GAIN_AB_BIT];
            sense_gain_pair2 <= motor_config_word[`MDS_GAIN_CD_BIT];
            blank_time_pair1 <=
                motor_config_word[`MDS_BLK_AB_MSB:`MDS_BLK_AB_LSB];
            blank_time_pair2 <=
                motor_config_word[`MDS_BLK_CD_MSB:`MDS_BLK_CD_LSB];
        end
    end

    // --------------------------------------------------------------
    // Wake timer and bridge enable
    // --------------------------------------------------------------
    logic [9:0] wake_cnt;
    logic run;

    assign run = rin_q && slp_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_cnt <= '0;
            wake_ready <= 1'b0;
            bridges_active <= 1'b0;
        end else begin
            bridges_active <= run;
            if (!run) begin
                wake_cnt <= '0;
                wake_ready <= 1'b0;
            end else if (wake_cnt >= 10'(WAKE_CYC - 1)) begin
                wake_ready <= 1'b1;
            end else begin
                wake_cnt <= wake_cnt + 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // Chopping oscillator
    // --------------------------------------------------------------
    logic [4:0] osc_cnt;
    logic [4:0] osc_half;

    always_comb begin
        case (chop_osc_freq_sel)
            2'h0: osc_half = 5'(`MDS_OSC_0_NS / `MDS_CLK_PERIOD_NS);
            2'h1: osc_half = 5'(`MDS_OSC_1_NS / `MDS_CLK_PERIOD_NS);
            2'h2: osc_half = 5'(`MDS_OSC_2_NS / `MDS_CLK_PERIOD_NS);
            default: osc_half = 5'(`MDS_OSC_3_NS / `MDS_CLK_PERIOD_NS);
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_cnt <= '0;
            chop_osc <= 1'b0;
        end else if (osc_cnt + 5'h01 >= osc_half) begin
            osc_cnt <= '0;
            chop_osc <= !chop_osc;
        end else begin
            osc_cnt <= osc_cnt + 5'h01;
        end
    end

    // --------------------------------------------------------------
    // Bridge enable and phase routing
    // --------------------------------------------------------------
    // In DC modes the port pins turn into enable and phase inputs.
    // Bridge A takes its enable from the latch pin and its phase from
    // the serial clock pin, which is sampled here as a plain level.
    logic sck1, sck2, sck3, sck_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sck1 <= 1'b0;
            sck2 <= 1'b0;
            sck3 <= 1'b0;
            sck_q <= 1'b0;
        end else begin
            sck1 <= serial_clock_ab;
            sck2 <= sck1;
            sck3 <= sck2;
            if (sck2 == sck3) begin
                sck_q <= sck3;
            end
        end
    end

    logic [3:0] en_pin;
    logic [3:0] ph_pin;
    logic [3:0] en_sel;
    logic [3:0] ph_sel;

    assign en_pin = {pin_q[6], pin_q[4], pin_q[2], latch_q};
    assign ph_pin = {pin_q[7], pin_q[5], pin_q[3], sck_q};

    always_comb begin
        en_sel = '0;
        ph_sel = '0;
        case (mds_motor_sel_t'(motor_select))
            MDS_MS_FOUR_SDC: begin
                en_sel = en_pin;
                ph_sel = ph_pin;
            end
            MDS_MS_TWO_LDC: begin
                en_sel = {en_pin[2], en_pin[2], en_pin[0], en_pin[0]};
                ph_sel = {ph_pin[2], ph_pin[2], ph_pin[0], ph_pin[0]};
            end
            MDS_MS_ULTRA_DC: begin
                en_sel = {4{en_pin[0]}};
                ph_sel = {4{ph_pin[0]}};
            end
            MDS_MS_LDC_2SDC: begin
                en_sel = {en_pin[3], en_pin[2], en_pin[0], en_pin[0]};
                ph_sel = {ph_pin[3], ph_pin[2], ph_pin[0], ph_pin[0]};
            end
            MDS_MS_STEP_2SDC: begin
                en_sel = {en_pin[3], en_pin[2], 2'b00};
                ph_sel = {ph_pin[3], ph_pin[2], 2'b00};
            end
            MDS_MS_STEP_LDC: begin
                en_sel = {en_pin[2], en_pin[2], 2'b00};
                ph_sel = {ph_pin[2], ph_pin[2], 2'b00};
            end
            default: begin
                en_sel = '0;
                ph_sel = '0;
            end
        endcase
    end

    // --------------------------------------------------------------
    // Current chopping per bridge
    // --------------------------------------------------------------
    logic [3:0] trip;
    logic [3:0] chop_drive;
    logic [7:0] blank_ab;
    logic [7:0] blank_cd;

    // Comparators A and B sit on ref_level_ab, C and D on ref_level_cd.
    assign trip = pin_q[11:8];

    function automatic logic [7:0] blank_cycles(input logic [1:0] code);
        case (code)
            2'h0: blank_cycles = 8'(`MDS_BLANK_CYC(`MDS_BLANK_0_NS));
            2'h1: blank_cycles = 8'(`MDS_BLANK_CYC(`MDS_BLANK_1_NS));
            2'h2: blank_cycles = 8'(`MDS_BLANK_CYC(`MDS_BLANK_2_NS));
            default: blank_cycles = 8'(`MDS_BLANK_CYC(`MDS_BLANK_3_NS));
        endcase
    endfunction : blank_cycles

    assign blank_ab = blank_cycles(blank_time_pair1);
    assign blank_cd = blank_cycles(blank_time_pair2);

    for (genvar b = 0; b < 4; b++) begin : g_chop
        mds_chopper #(.CNT_W(8)) u_chop (
            .clk(clk),
            .rst(rst),
            .run(run),
            .trip(trip[b]),
            .off_cycles((b < 2) ? blank_ab : blank_cd),
            .blank_cycles((b < 2) ? blank_ab : blank_cd),
            .drive(chop_drive[b])
        );
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bridge_drive <= '0;
            bridge_phase <= '0;
        end else begin
            bridge_drive <= run ? (en_sel & chop_drive) : 4'h0;
            bridge_phase <= run ? ph_sel : 4'h0;
        end
    end
endmodule : mds_setup_port
`default_nettype wire

// *** verif/mds_host_model.sv ***
// Host controller model: frames words onto the setup port, and in direct
// mode passes bridge A enable and phase onto the shared pins.
// Assumes go rises only while no frame is in progress.
`timescale 1ns/1ps
`default_nettype none
module mds_host_model
    import mds_pkg::*;
(
    input wire logic go,
    input wire logic [15:0] word,
    input wire logic to_ext,
    input wire logic direct,
    input wire logic en_a,
    input wire logic ph_a,
    output logic serial_clock_ab,
    output var logic serial_in_ab,
    output logic latch_a,
    output var logic done
);
    logic sck;
    logic stb;
    assign serial_clock_ab = direct ? ph_a : sck;
    assign latch_a = direct ? en_a : stb;
    initial begin
        sck = 1'b0;
        stb = 1'b0;
        serial_in_ab = 1'b0;
        done = 1'b0;
    end
    // The link clock runs only inside a frame; data is held through latch.
    always @(posedge go) begin
        done = 1'b0;
        stb = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            #3.75 serial_in_ab = word[i];
            #3.75 sck = 1'b1;
            #7.5 sck = 1'b0;
        end
        #3.75 serial_in_ab = to_ext;
        #400 stb = 1'b1;
        #500 stb = 1'b0;
        serial_in_ab = ~serial_in_ab;
        done = 1'b1;
    end
endmodule : mds_host_model
`default_nettype wire

// *** verif/mds_setup_port_props.sv ***
// Concurrent checks on the setup port outputs.
// Assumes it is bound onto mds_setup_port and shares its port names.
`timescale 1ns/1ps
`default_nettype none
module mds_props
    import mds_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic device_reset_in,
    input wire logic low_power_select_n,
    input wire logic pin_b_phase,
    input wire logic [15:0] motor_config_word,
    input wire logic [15:0] extended_word,
    input wire logic config_update,
    input wire logic bridges_active,
    input wire logic [3:0] bridge_drive,
    input wire logic [3:0] bridge_phase,
    input wire logic [2:0] motor_select,
    input wire logic [1:0] chop_osc_freq_sel,
    input wire logic sense_gain_pair1,
    input wire logic sense_gain_pair2,
    input wire logic [1:0] blank_time_pair1,
    input wire logic [1:0] blank_time_pair2,
    input wire logic wake_ready
);
    logic [9:0] run_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_cnt <= 10'h000;
        end else if (!bridges_active) begin
            run_cnt <= 10'h000;
        end else if (run_cnt != 10'h3FF) begin
            run_cnt <= run_cnt + 10'h001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    cfg_load_only_a: assert property (
        $changed(motor_config_word) && motor_config_word != 16'h0000
        |-> config_update) else $error("word changed without update");
    update_pulse_a: assert property (
        config_update |=> !config_update) else $error("update too long");
    motor_decode_a: assert property (
        1'b1 |=> motor_select == $past(motor_config_word[2:0]))
        else $error("motor select decode wrong");
    field_decode_a: assert property (
        1'b1 |=> {chop_osc_freq_sel, sense_gain_pair2, sense_gain_pair1,
        blank_time_pair2, blank_time_pair1} == {$past(motor_config_word[15:14]),
        $past(motor_config_word[11:10]), $past(motor_config_word[6:3])})
        else $error("field decode wrong");
    reset_in_clear_a: assert property (
        !device_reset_in [*6] |-> motor_config_word == 16'h0000
        && extended_word == 16'h0000 && !bridges_active)
        else $error("reset input not honoured");
    sleep_off_a: assert property (
        !low_power_select_n [*6] |-> !bridges_active && bridge_drive == 4'h0)
        else $error("bridges on in setup");
    sleep_clear_a: assert property (
        $fell(low_power_select_n) |-> ##6 motor_config_word == 16'h0000)
        else $error("sleep did not clear word");
    run_on_a: assert property (
        (device_reset_in && low_power_select_n) [*8] |-> bridges_active)
        else $error("bridges not enabled");
    phase_own_a: assert property (
        (bridges_active && motor_select == 3'h5 && $stable(pin_b_phase)) [*6]
        |-> bridge_phase[1] == pin_b_phase) else $error("phase b not own");
    wake_early_a: assert property (
        bridges_active && run_cnt < 10'h1F0 |-> !wake_ready)
        else $error("wake ready too early");
    cover property (config_update);
    cover property (bridges_active && motor_select == 3'h5);
    cover property ($rose(wake_ready));
endmodule : mds_props
bind mds_setup_port mds_props u_props (.*);
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the motor driver setup port.
// Assumes the host model on the serial pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import mds_pkg::*;
;
    logic clk, rst, device_reset_in, low_power_select_n;
    logic pin_b_enable, pin_b_phase, pin_c_enable, pin_c_phase;
    logic pin_d_enable, pin_d_phase, config_update, bridges_active;
    logic sense_gain_pair1, sense_gain_pair2, chop_osc, wake_ready;
    logic go, to_ext, direct, en_a, ph_a, done;
    logic [3:0] sense_over_ref, bridge_drive, bridge_phase, e, p;
    logic [15:0] motor_config_word, extended_word, hword, w;
    logic [2:0] motor_select;
    logic [1:0] chop_osc_freq_sel, blank_time_pair1, blank_time_pair2;
    wire logic serial_clock_ab, latch_a, serial_in_ab;
    int fails, n_checks, seed, n;
    logic [2:0] modes [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    mds_setup_port DUT (.*);
    mds_host_model host (.go(go), .word(hword), .to_ext(to_ext),
        .direct(direct), .en_a(en_a), .ph_a(ph_a), .done(done),
        .serial_clock_ab(serial_clock_ab), .serial_in_ab(serial_in_ab),
        .latch_a(latch_a));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [3:0] route(input logic [2:0] ms,
                                         input logic [3:0] v);
        case (ms)
            3'h5: return v;
            3'h2: return {v[3], v[2], 2'b00};
            3'h3: return {v[3], v[2], v[0], v[0]};
            3'h4: return {v[2], v[2], v[0], v[0]};
            3'h7: return {4{v[0]}};
            default: return 4'h0;
        endcase
    endfunction : route
    function automatic int blank_cyc(input logic [1:0] c);
        return (c == 2'h0) ? 62 : (c == 2'h1) ? 75 : (c == 2'h2) ? 37 : 50;
    endfunction : blank_cyc
    function automatic int osc_half(input logic [1:0] c);
        return (c == 2'h0) ? 12 : (c == 2'h1) ? 25 : (c == 2'h2) ? 9 : 6;
    endfunction : osc_half
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask : tick
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic send(input logic [15:0] x, input logic ext);
        @(posedge clk);
        hword <= x;
        to_ext <= ext;
        go <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (done !== 1'b1 && n < 40);
        go <= 1'b0;
        if (n >= 40) fails++;
        tick(8);
    endtask : send
    task automatic pins(input logic [3:0] en, input logic [3:0] ph);
        @(posedge clk);
        en_a <= en[0];
        pin_b_enable <= en[1];
        pin_c_enable <= en[2];
        pin_d_enable <= en[3];
        ph_a <= ph[0];
        pin_b_phase <= ph[1];
        pin_c_phase <= ph[2];
        pin_d_phase <= ph[3];
    endtask : pins
    task automatic chop(input int b, input int exp);
        int k;
        @(posedge clk);
        sense_over_ref[b] <= 1'b1;
        tick(2);
        sense_over_ref <= 4'h0;
        k = 0;
        n = 0;
        while (bridge_drive[b] !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        check("other pair", 16'(bridge_drive[b ^ 2]), 16'h0001);
        while (bridge_drive[b] === 1'b0 && k < 200) begin
            @(negedge clk);
            k++;
        end
        check("off time", 16'(k >= exp - 1 && k <= exp + 1), 16'h0001);
    endtask : chop
    initial begin
        #2_000_000;
        fails++;
        close_out();
    end
    //--------------------------------------------------------------
    // Scenarios
    //--------------------------------------------------------------
    initial begin
        seed = 45;
        rst = 1'b1;
        device_reset_in = 1'b1;
        low_power_select_n = 1'b0;
        sense_over_ref = 4'h0;
        {go, to_ext, direct, en_a, ph_a, hword} = '0;
        {pin_b_enable, pin_b_phase, pin_c_enable, pin_c_phase} = 4'h0;
        {pin_d_enable, pin_d_phase} = 2'h0;
        tick(4);
        rst <= 1'b0;
        tick(8);
        check("cfg reset", motor_config_word, 16'h0000);
        check("ext reset", extended_word, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            w = 16'($random(seed));
            send(w, 1'b0);
            check("cfg", motor_config_word, w);
        end
        send(~w, 1'b1);
        check("ext", extended_word, ~w);
        check("cfg kept", motor_config_word, w);
        @(posedge clk);
        device_reset_in <= 1'b0;
        tick(6);
        send(16'hFFFF, 1'b0);
        check("held", motor_config_word, 16'h0000);
        @(posedge clk);
        device_reset_in <= 1'b1;
        tick(6);
        foreach (modes[j]) begin
            w = 16'($random(seed));
            w[2:0] = modes[j];
            send(w, 1'b0);
            check("mode", 16'(motor_select), 16'(modes[j]));
            @(posedge clk);
            low_power_select_n <= 1'b1;
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (wake_ready !== 1'b1 && n < 600);
            check("wake wait", 16'(n >= 500 && n < 600), 16'h0001);
            check("active", 16'(bridges_active), 16'h0001);
            e[0] = chop_osc;
            n = 0;
            while (chop_osc === e[0] && n < 60) begin
                @(negedge clk);
                n++;
            end
            e[0] = chop_osc;
            n = 0;
            while (chop_osc === e[0] && n < 60) begin
                @(negedge clk);
                n++;
            end
            check("osc half", 16'(n), 16'(osc_half(w[15:14])));
            @(posedge clk);
            direct <= 1'b1;
            for (int k = 0; k < 4; k++) begin
                e = 4'($random(seed));
                p = 4'($random(seed));
                pins(e, p);
                tick(8);
                check("drive", 16'(bridge_drive), 16'(route(w[2:0], e)));
                if (modes[j] != 3'h0) begin
                    check("phase", 16'(bridge_phase), 16'(route(w[2:0], p)));
                end
            end
            if (modes[j] == 3'h5) begin
                pins(4'hF, 4'h0);
                tick(8);
                chop(0, blank_cyc(w[4:3]));
                chop(2, blank_cyc(w[6:5]));
            end
            pins(4'h0, 4'h0);
            @(posedge clk);
            direct <= 1'b0;
            send(~w, 1'b0);
            check("refused", motor_config_word, w);
            @(posedge clk);
            low_power_select_n <= 1'b0;
            tick(8);
            check("sleep clear", motor_config_word, 16'h0000);
            check("sleep off", 16'(bridge_drive), 16'h0000);
        end
        close_out();
    end
endmodule : tb_top
`default_nettype wire
